// ===== rtl/atos_pkg.sv
// Purpose: shared constants and types for the alert-triggered output select block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: printed offsets are not word multiples, so they are indices; byte address = 4 * index
package atos_pkg;
    localparam int ATOS_CHANNELS = 8;
    localparam int ATOS_OUTPUTS = 5;
    localparam int ATOS_ADDR_W = 12;
    // register indices as printed
    localparam logic [9:0] ATOS_IDX_MASK0 = 10'h0c3;
    localparam logic [9:0] ATOS_IDX_MASK1 = 10'h0c5;
    localparam logic [9:0] ATOS_IDX_MASK2 = 10'h0c7;
    localparam logic [9:0] ATOS_IDX_MASK3 = 10'h0c9;
    localparam logic [9:0] ATOS_IDX_MASK4 = 10'h0cb;
    // interrupt registers placed past the mask block
    localparam logic [9:0] ATOS_IDX_IRQ_STATUS = 10'h0e0;
    localparam logic [9:0] ATOS_IDX_IRQ_ENABLE = 10'h0e1;
    // mask and interrupt enable reset values
    localparam logic [7:0] ATOS_RST_MASK0 = 8'h02;
    localparam logic [7:0] ATOS_RST_MASK1 = 8'h01;
    localparam logic [7:0] ATOS_RST_MASK2 = 8'h08;
    localparam logic [7:0] ATOS_RST_MASK3 = 8'h04;
    localparam logic [7:0] ATOS_RST_MASK4 = 8'h20;
    localparam logic [4:0] ATOS_RST_IRQ_ENABLE = 5'h00;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ATOS_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } atos_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } atos_apb_rsp_t;
endpackage : atos_pkg

// ===== rtl/atos_apb_decode.sv
// Purpose: apb address decode into a register index
// Assumes: word-aligned accesses; unaligned addresses count as unmapped
// Notes: purely combinational
`timescale 1ns/1ps
module atos_apb_decode (
    input wire atos_pkg::atos_apb_req_t req,
    output logic access,
    output logic [9:0] index,
    output logic aligned
);
    import atos_pkg::*;

    // access phase qualifies every register effect
    always_comb begin
        access = req.psel && req.penable;
        index = req.paddr[ATOS_ADDR_W-1:2];
        aligned = (req.paddr[1:0] == 2'h0);
    end
endmodule : atos_apb_decode

// ===== rtl/atos_trigger_or.sv
// Purpose: per-output selection of channel alerts
// Assumes: alert flags already in the clock domain
// Notes: one instance per output
`timescale 1ns/1ps
module atos_trigger_or #(
    parameter int CHANNELS = 8
) (
    input wire logic [CHANNELS-1:0] mask,
    input wire logic [CHANNELS-1:0] alert,
    output logic fire
);
    // clear mask bits block their channel; any selected one fires
    always_comb begin
        fire = |(mask & alert);
    end
endmodule : atos_trigger_or

// ===== rtl/atos_top.sv
// Purpose: alert-triggered output select mask bank with apb access
// Assumes: alert flags come from the watchdog on the same clock
// Notes: registers one update strobe per general output, high in each cycle after a selected alert is seen
// Notes on behaviour
// - output 0 mask, bit n selects channel n
// - set mask bit lets channel alert update
// - clear mask bit blocks that channel alert
// - outputs 1 to 4 have own masks
// - output 0 mask index c3, reset 02
// - output 1 mask index c5, reset 01
// - output 2 mask index c7, reset 08
// - output 3 mask index c9, reset 04
// - output 4 mask index cb, reset 20
`timescale 1ns/1ps
module atos_top #(
    parameter int CHANNELS = atos_pkg::ATOS_CHANNELS,
    parameter int OUTPUTS = atos_pkg::ATOS_OUTPUTS
) (
    input wire logic clk,
    input wire logic rst,
    input wire atos_pkg::atos_apb_req_t apb_req,
    output atos_pkg::atos_apb_rsp_t apb_rsp,
    input wire logic [CHANNELS-1:0] alert_flags,
    output logic [OUTPUTS-1:0] output_update,
    output logic irq
);
    import atos_pkg::*;

    // the mask layout and map are fixed at eight channels and five outputs
    if (CHANNELS != ATOS_CHANNELS || OUTPUTS != ATOS_OUTPUTS) begin : g_bad_params
        $error("atos_top: only 8 channels and 5 outputs are supported");
    end

    typedef struct packed {
        logic [OUTPUTS-1:0][CHANNELS-1:0] mask;
        logic [OUTPUTS-1:0] update;
        logic [OUTPUTS-1:0] irq_status;
        logic [OUTPUTS-1:0] irq_enable;
        logic [31:0] rdata;
        logic slverr;
    } atos_state_t;

    atos_state_t state;
    atos_state_t next_state;
    logic access;
    logic [9:0] index;
    logic aligned;
    logic [OUTPUTS-1:0] fire;
    logic [9:0] mask_index [OUTPUTS];
    logic [CHANNELS-1:0] mask_reset [OUTPUTS];

    atos_apb_decode u_decode (
        .req(apb_req),
        .access(access),
        .index(index),
        .aligned(aligned)
    );

    // map table for the five mask registers
    always_comb begin
        mask_index[0] = ATOS_IDX_MASK0;
        mask_index[1] = ATOS_IDX_MASK1;
        mask_index[2] = ATOS_IDX_MASK2;
        mask_index[3] = ATOS_IDX_MASK3;
        mask_index[4] = ATOS_IDX_MASK4;
        mask_reset[0] = ATOS_RST_MASK0;
        mask_reset[1] = ATOS_RST_MASK1;
        mask_reset[2] = ATOS_RST_MASK2;
        mask_reset[3] = ATOS_RST_MASK3;
        mask_reset[4] = ATOS_RST_MASK4;
    end

    // one selector per output, each against its own mask
    for (genvar g = 0; g < OUTPUTS; g++) begin : g_out
        atos_trigger_or #(
            .CHANNELS(CHANNELS)
        ) u_sel (
            .mask(state.mask[g]),
            .alert(alert_flags),
            .fire(fire[g])
        );
    end

    // register file, strobes and interrupt status
    always_comb begin
        logic hit;
        hit = 1'b0;
        next_state = state;
        // strobe evaluated with the mask held before any write this cycle
        next_state.update = fire;
        // set wins over a write-one clear in the same cycle
        next_state.irq_status = state.irq_status | fire;
        next_state.rdata = 32'h0;
        next_state.slverr = 1'b0;
        if (access && aligned) begin
            for (int k = 0; k < OUTPUTS; k++) begin
                if (index == mask_index[k]) begin
                    hit = 1'b1;
                    next_state.rdata = {24'h0, state.mask[k]};
                    if (apb_req.pwrite) begin
                        next_state.mask[k] = apb_req.pwdata[CHANNELS-1:0];
                    end
                end
            end
            if (index == ATOS_IDX_IRQ_STATUS) begin
                hit = 1'b1;
                next_state.rdata = {27'h0, state.irq_status};
                if (apb_req.pwrite) begin
                    next_state.irq_status = (state.irq_status & ~apb_req.pwdata[OUTPUTS-1:0]) | fire;
                end
            end
            if (index == ATOS_IDX_IRQ_ENABLE) begin
                hit = 1'b1;
                next_state.rdata = {27'h0, state.irq_enable};
                if (apb_req.pwrite) begin
                    next_state.irq_enable = apb_req.pwdata[OUTPUTS-1:0];
                end
            end
        end
        // unmapped or unaligned: error, reads zero
        if (access && !hit) begin
            next_state.slverr = 1'b1;
        end
        if (rst) begin
            for (int k = 0; k < OUTPUTS; k++) begin
                next_state.mask[k] = mask_reset[k];
            end
            next_state.update = '0;
            next_state.irq_status = '0;
            next_state.irq_enable = ATOS_RST_IRQ_ENABLE;
            next_state.rdata = 32'h0;
            next_state.slverr = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
    end

    // zero-wait slave: data is valid in the access cycle, so drive combinationally from the mask and interrupt registers
    always_comb begin
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = 1'b0;
        apb_rsp.prdata = 32'h0;
        if (access) begin
            apb_rsp.pslverr = !(aligned && (index == ATOS_IDX_IRQ_STATUS || index == ATOS_IDX_IRQ_ENABLE
                || index == mask_index[0] || index == mask_index[1] || index == mask_index[2]
                || index == mask_index[3] || index == mask_index[4]));
            for (int k = 0; k < OUTPUTS; k++) begin
                if (aligned && index == mask_index[k]) begin
                    apb_rsp.prdata = {24'h0, state.mask[k]};
                end
            end
            if (aligned && index == ATOS_IDX_IRQ_STATUS) begin
                apb_rsp.prdata = {27'h0, state.irq_status};
            end
            if (aligned && index == ATOS_IDX_IRQ_ENABLE) begin
                apb_rsp.prdata = {27'h0, state.irq_enable};
            end
        end
    end

    // outputs from flops
    always_comb begin
        output_update = state.update;
        irq = |(state.irq_status & state.irq_enable);
    end

    // ---- checks ----
    // reset checks look one edge ahead, so no history before the first edge is needed
    a_mask0_reset: assert property (@(posedge clk) rst |=> state.mask[0] == ATOS_RST_MASK0)
        else $error("mask0 reset value wrong");
    a_mask1_reset: assert property (@(posedge clk) rst |=> state.mask[1] == ATOS_RST_MASK1)
        else $error("mask1 reset value wrong");
    a_mask2_reset: assert property (@(posedge clk) rst |=> state.mask[2] == ATOS_RST_MASK2)
        else $error("mask2 reset value wrong");
    a_mask3_reset: assert property (@(posedge clk) rst |=> state.mask[3] == ATOS_RST_MASK3)
        else $error("mask3 reset value wrong");
    a_mask4_reset: assert property (@(posedge clk) rst |=> state.mask[4] == ATOS_RST_MASK4)
        else $error("mask4 reset value wrong");
    a_selected_fires: assert property (@(posedge clk) disable iff (rst)
        ((alert_flags & state.mask[0]) != 8'h00) |=> output_update[0])
        else $error("selected alert did not update output 0");
    a_blocked_quiet: assert property (@(posedge clk) disable iff (rst)
        ((alert_flags & state.mask[1]) == 8'h00) |=> !output_update[1])
        else $error("unselected alert updated output 1");
    a_or_of_alerts: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> output_update[2] == |($past(alert_flags) & $past(state.mask[2])))
        else $error("output 2 strobe is not the or of selected alerts");
    a_mask_write: assert property (@(posedge clk) disable iff (rst)
        (access && apb_req.pwrite && aligned && index == ATOS_IDX_MASK3)
        |=> state.mask[3] == $past(apb_req.pwdata[7:0]))
        else $error("mask3 write not stored");
    a_mask_own: assert property (@(posedge clk) disable iff (rst)
        (access && apb_req.pwrite && aligned && index == ATOS_IDX_MASK4)
        |=> $stable(state.mask[0]))
        else $error("mask4 write disturbed mask0");
    a_mask_readback: assert property (@(posedge clk) disable iff (rst)
        (access && !apb_req.pwrite && aligned && index == ATOS_IDX_MASK0)
        |-> apb_rsp.prdata == {24'h0, state.mask[0]})
        else $error("mask0 readback wrong");
endmodule : atos_top

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the alert-triggered output select bank
// Assumes: zero-wait apb slave, update pulse one cycle after the alert edge
// Notes: drivers queue expectations, one monitor compares them as results appear
`timescale 1ns/1ps
module tb_top;
    import atos_pkg::*;
    logic clk;
    logic rst;
    atos_apb_req_t req;
    atos_apb_rsp_t rsp;
    logic [7:0] alert_flags;
    logic [4:0] output_update;
    logic irq;
    logic [32:0] rd_q[$];
    logic [31:0] ev_q[$];
    logic [5:0] pend = 6'h00;
    logic [31:0] cyc = 32'h0;
    logic [7:0] mm [5] = '{8'h02, 8'h01, 8'h08, 8'h04, 8'h20};
    logic [4:0] st = 5'h00;
    logic [4:0] en = 5'h00;
    logic [11:0] maddr [5];
    int miscompares = 0;
    int comparisons = 0;
    integer seed = 32'h6364f1a0;

    atos_top i_atos_top (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .alert_flags(alert_flags),
        .output_update(output_update), .irq(irq));

    // free-running clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic conclude();
        if (miscompares == 0 && comparisons > 0 && rd_q.size() == 0 && ev_q.size() == 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [32:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= wd;
        if (!wr) rd_q.push_back(exp);
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            conclude();
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    // drive one alert pattern and note the edge at which its update and irq are due
    task automatic alert(input logic [7:0] a);
        @(posedge clk);
        alert_flags <= a;
        ev_q.push_back(cyc + 32'd2);
    endtask : alert

    // monitor: one process owns the model, so mask writes and alerts in one edge never race
    always @(posedge clk) begin
        logic [31:0] n;
        logic [32:0] e;
        logic [4:0] u;
        cyc <= cyc + 32'd1;
        if (ev_q.size() > 0 && ev_q[0] == cyc) begin
            n = ev_q.pop_front();
            chk({27'h0, irq, output_update}, {27'h0, pend});
        end
        // alerts are judged with the mask held before any write at this edge
        for (int i = 0; i < 5; i++) u[i] = |(alert_flags & mm[i]);
        if (req.psel && req.penable && rsp.pready === 1'b1 && req.pwrite) begin
            for (int k = 0; k < 5; k++) if (req.paddr == maddr[k]) mm[k] = req.pwdata[7:0];
            if (req.paddr == 12'h380) st = st & ~req.pwdata[4:0];
            if (req.paddr == 12'h384) en = req.pwdata[4:0];
        end
        st = st | u; // set wins over a clear in the same edge
        pend = {|(st & en), u};
        if (rst) begin
            mm = '{8'h02, 8'h01, 8'h08, 8'h04, 8'h20};
            st = 5'h00;
            en = 5'h00;
            pend = 6'h00;
        end
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
            e = (rd_q.size() > 0) ? rd_q.pop_front() : '1;
            chk({rsp.pslverr, rsp.prdata}, e);
        end
    end

    initial begin
        logic [31:0] wd;
        maddr = '{{ATOS_IDX_MASK0, 2'b00}, {ATOS_IDX_MASK1, 2'b00}, {ATOS_IDX_MASK2, 2'b00},
            {ATOS_IDX_MASK3, 2'b00}, {ATOS_IDX_MASK4, 2'b00}};
        req = '0;
        alert_flags = 8'h00;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // reset values, then refused places and a write that must not land
        for (int i = 0; i < 5; i++) apb(1'b0, maddr[i], 32'h0, {25'h0, mm[i]});
        apb(1'b0, 12'h380, 32'h0, 33'h0);
        apb(1'b0, 12'h384, 32'h0, 33'h0);
        apb(1'b1, 12'h310, 32'hffffffff, 33'h0);
        apb(1'b0, 12'h310, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 12'h30d, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 12'h300, 32'h0, {1'b1, 32'h0});
        // walking one channel at a time through the default masks
        for (int n = 0; n < 8; n++) alert(8'h01 << n);
        alert(8'h00);
        // random masks with junk in the upper bits, read back
        for (int i = 0; i < 5; i++) begin
            wd = $random(seed);
            apb(1'b1, maddr[i], wd, 33'h0);
            apb(1'b0, maddr[i], 32'h0, {25'h0, wd[7:0]});
        end
        // random alert stream while a mask changes under it
        fork
            begin
                repeat (40) alert(8'($random(seed)));
                alert(8'h00);
                alert(8'h00);
            end
            begin
                repeat (5) @(posedge clk);
                apb(1'b1, maddr[2], 32'hffffff5a, 33'h0);
                apb(1'b0, maddr[2], 32'h0, {25'h0, 8'h5a});
            end
        join
        // interrupt: clear, raise while masked, unmask, clear again
        apb(1'b0, 12'h380, 32'h0, {28'h0, st});
        apb(1'b1, 12'h380, 32'h1f, 33'h0);
        apb(1'b1, maddr[0], 32'h80, 33'h0);
        alert(8'h80);
        alert(8'h00);
        alert(8'h00);
        apb(1'b1, 12'h384, {27'h0, ~st}, 33'h0);
        alert(8'h00);
        apb(1'b1, 12'h384, 32'h1f, 33'h0);
        alert(8'h00);
        apb(1'b0, 12'h384, 32'h0, 33'h1f);
        apb(1'b1, 12'h380, {27'h0, st}, 33'h0);
        alert(8'h00);
        apb(1'b0, 12'h380, 32'h0, 33'h0);
        // reset again in mid-run: the written mask must return to its default
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, maddr[0], 32'h0, 33'h02);
        alert(8'h02);
        alert(8'h00);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : tb_top
